// [logic/reset_defaults_pkg.sv]
// Package: register map, reset values and boot states of the reset default loader.
// Assumes one 200 MHz clock and a 32-bit AXI4-Lite register bus.
`default_nettype none
package reset_defaults_pkg;
  localparam int ADDR_W = 12;
  localparam int REG_COUNT = 78;
  localparam int MEM_DEPTH = 64;
  localparam int MEM_AW = 6;
  // Byte addresses of the status words and the data memory window
  localparam logic [11:0] IP_LO_ADDR = 12'h0138;
  localparam logic [11:0] IP_HI_ADDR = 12'h013C;
  localparam logic [11:0] STATUS_ADDR = 12'h0140;
  localparam logic [11:0] MEM_BASE = 12'h0400;
  localparam logic [11:0] MEM_END = 12'h0500;
  // Reset vector table bytes inside the data memory
  localparam logic [5:0] VECTOR_LO_IDX = 6'h00;
  localparam logic [5:0] VECTOR_HI_IDX = 6'h01;
  // Register indices; byte address is four times the index
  localparam int PORT_LATCH_IDX = 0;
  localparam int PORT_DIR_IDX = 6;
  localparam int PULLUP_IDX = 14;
  localparam int MEM_SIZE_IDX = 18;
  localparam int CLK_MODE_IDX = 19;
  localparam int PROC_CLK_IDX = 20;
  localparam int INT_OSC_IDX = 21;
  localparam int MAIN_OSC_IDX = 22;
  localparam int MAIN_CLK_MODE_IDX = 23;
  localparam int SETTLE_STATUS_IDX = 24;
  localparam int SETTLE_SEL_IDX = 25;
  localparam int WIDE_TIMER_IDX = 26;
  localparam int BYTE_CTR_IDX = 36;
  localparam int INTERVAL_IDX = 44;
  localparam int WATCH_IDX = 51;
  localparam int WDT_IDX = 53;
  localparam int ADC_IDX = 54;
  localparam int SERIAL_A_IDX = 60;
  localparam int SERIAL_B_IDX = 65;
  localparam int CSI_IDX = 74;
  // Watchdog enable codes picked by the option setting
  localparam logic [7:0] WDT_CODE_CLR = 8'h1A;
  localparam logic [7:0] WDT_CODE_SET = 8'h9A;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // Values after reset, index 0 first; the watchdog entry is replaced by the option code
  localparam logic [7:0] REG_DEFAULT [REG_COUNT] = '{
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,                       // Port output latches
    8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF,         // Port directions
    8'h00, 8'h00, 8'h00, 8'h00,                                     // Pull-up options
    8'hCF, 8'h00, 8'h01, 8'h80, 8'h80, 8'h00, 8'h00, 8'h05,         // Memory size, clocks, settle
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,                       // Wide timer count, capcmp a/b
    8'h00, 8'h00, 8'h00, 8'h00,                                     // Wide timer controls
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,         // Byte counters a/b
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,                // Interval timers, carrier
    8'h00, 8'h00, 8'h00,                                            // Watch, clock out, watchdog
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,                       // Converter
    8'hFF, 8'hFF, 8'h01, 8'h00, 8'h1F,                              // Serial a
    8'hFF, 8'hFF, 8'h01, 8'h00, 8'h00, 8'h00, 8'hFF, 8'h16, 8'h00,  // Serial b, switch
    8'h00, 8'h00, 8'h00, 8'h00                                      // Clocked serial
  };
  typedef enum logic [1:0] {
    HOLD_ST = 2'b00,
    FETCH_LO_ST = 2'b01,
    FETCH_HI_ST = 2'b11,
    RUN_ST = 2'b10
  } boot_state_type;
endpackage : reset_defaults_pkg
`default_nettype wire

// [logic/level_sync.sv]
// Three-stage synchroniser for a level from outside the clock domain.
// Assumes the input changes slowly compared with the clock.
`timescale 1ns/100ps
`default_nettype none
module level_sync (
  input wire logic aclk,    // System clock
  input wire logic async_in, // Level from outside
  output logic sync_out     // Filtered level
);
  logic stage1_q;
  logic stage2_q;
  logic stage3_q;

  // Accept a change once the last two stages agree
  always_ff @(posedge aclk) begin
    stage1_q <= async_in;
    stage2_q <= stage1_q;
    stage3_q <= stage2_q;
    if (stage2_q == stage3_q) begin
      sync_out <= stage3_q;
    end
  end
endmodule : level_sync
`default_nettype wire

// [logic/data_memory.sv]
// Byte-wide data memory with registered read data and no reset.
// Assumes the caller blocks writes while the contents must be kept.
`timescale 1ns/100ps
`default_nettype none
module data_memory #(
  parameter int DEPTH = 64,
  parameter int AW = 6
) (
  input wire logic aclk,              // System clock
  input wire logic wr_en,             // Write strobe
  input wire logic [AW-1:0] wr_addr,  // Write index
  input wire logic [7:0] wr_data,     // Write byte
  input wire logic [AW-1:0] rd_addr,  // Read index
  output logic [7:0] rd_data          // Registered read byte
);
  logic [7:0] mem [DEPTH];

  // Contents are never cleared, so they live through any reset
  always_ff @(posedge aclk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule : data_memory
`default_nettype wire

// [logic/reset_default_state_loader.sv]
// Register bank that takes documented default values under reset and boots the pointer.
// Assumes AXI4-Lite master, option level from a pin, standby flag from same-clock logic.
// Overview of operation
// - Pointer loaded from vector bytes zero, one
// - During reset only pointer is undefined
// - Memory never cleared; standby reset keeps contents
// - Latches, pull-ups 00H; directions FFH
// - Memory size resets CFH; software rewrites
// - Clock mode registers take 00H/01H/80H
// - Settle status 00H, settle select 05H
// - Wide timer registers reset to zero
// - Both byte counters reset to zero
// - Interval timers and carrier reset zero
// - Watch mode and clock output zero
// - Converter registers reset to zero
// - Serial a: FFH, FFH, 01H, 00H, 1FH
// - Serial b buffers FFH, mode 01H, control 16H
// - Serial b status, clock, switch zero
// - Clocked serial registers reset to zero
// - Watchdog code 1AH or 9AH by option
//
// The placing of the registers and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module reset_default_state_loader
  import reset_defaults_pkg::*;
(
  input wire logic aclk,                       // 200 MHz clock
  input wire logic aresetn,                    // Synchronous reset, active low
  input wire logic [ADDR_W-1:0] awaddr,        // Write address
  input wire logic [2:0] awprot,               // Unused protection
  input wire logic awvalid,                    // Write address valid
  output logic awready,                        // Write address ready
  input wire logic [31:0] wdata,               // Write data
  input wire logic [3:0] wstrb,                // Byte enables
  input wire logic wvalid,                     // Write data valid
  output logic wready,                         // Write data ready
  output logic [1:0] bresp,                    // Write response
  output logic bvalid,                         // Write response valid
  input wire logic bready,                     // Write response ready
  input wire logic [ADDR_W-1:0] araddr,        // Read address
  input wire logic [2:0] arprot,               // Unused protection
  input wire logic arvalid,                    // Read address valid
  output logic arready,                        // Read address ready
  output logic [31:0] rdata,                   // Read data
  output logic [1:0] rresp,                    // Read response
  output logic rvalid,                         // Read data valid
  input wire logic rready,                     // Read data ready
  input wire logic standby_mode,               // Core is in a standby mode
  input wire logic option_wdt_sel,             // Option level for watchdog code
  output logic [8*REG_COUNT-1:0] reg_image,    // All peripheral registers, index 0 low
  output logic [15:0] instruction_pointer,     // Booted pointer
  output logic pointer_valid                   // Pointer holds the vector
);
  logic [7:0] regs_q [REG_COUNT];
  boot_state_type state_q;
  logic [7:0] ip_lo_q;
  logic [7:0] ip_hi_q;
  logic pointer_valid_q;
  logic retained_q;
  logic opt_sync;
  logic aw_held_q;
  logic w_held_q;
  logic [ADDR_W-1:0] wr_addr_q;
  logic [7:0] wr_byte_q;
  logic wr_lane_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic awready_q;
  logic wready_q;
  logic rd_pend_q;
  logic [ADDR_W-1:0] rd_addr_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic arready_q;
  logic [7:0] mem_rdata;

  // Address classes used by both the write and the read path
  function automatic logic is_reg(input logic [ADDR_W-1:0] a);
    return (a[1:0] == 2'b00) && (a < IP_LO_ADDR);
  endfunction : is_reg

  function automatic logic is_mem(input logic [ADDR_W-1:0] a);
    return (a[1:0] == 2'b00) && (a >= MEM_BASE) && (a < MEM_END);
  endfunction : is_mem

  // Option pin crosses into the clock domain
  level_sync u_opt_sync (
    .aclk(aclk),
    .async_in(option_wdt_sel),
    .sync_out(opt_sync)
  );

  // Handshake and write decode
  wire aw_take = awvalid && awready_q;
  wire w_take = wvalid && wready_q;
  wire do_write = aw_held_q && w_held_q;
  wire wr_reg_hit = is_reg(wr_addr_q);
  wire wr_mem_hit = is_mem(wr_addr_q);
  wire wr_ro_hit = (wr_addr_q == IP_LO_ADDR) || (wr_addr_q == IP_HI_ADDR) || (wr_addr_q == STATUS_ADDR);
  wire reg_we = aresetn && do_write && wr_lane_q && wr_reg_hit;
  wire mem_we = aresetn && do_write && wr_lane_q && wr_mem_hit;
  wire [6:0] wr_idx = wr_addr_q[8:2];
  wire aw_held_d = aw_held_q ? !do_write : aw_take;
  wire w_held_d = w_held_q ? !do_write : w_take;
  wire bvalid_d = do_write || (bvalid_q && !bready);
  wire run = (state_q == RUN_ST);

  // Read path decode
  wire ar_take = arvalid && arready_q;
  wire rvalid_d = rd_pend_q || (rvalid_q && !rready);
  wire [6:0] rd_idx = rd_addr_q[8:2];
  wire [7:0] status_byte = {5'b0_0000, opt_sync, retained_q, pointer_valid_q};
  wire [7:0] rd_byte = is_reg(rd_addr_q) ? regs_q[rd_idx] :
                       is_mem(rd_addr_q) ? mem_rdata :
                       (rd_addr_q == IP_LO_ADDR) ? ip_lo_q :
                       (rd_addr_q == IP_HI_ADDR) ? ip_hi_q :
                       (rd_addr_q == STATUS_ADDR) ? status_byte : 8'h00;
  wire rd_ok = is_reg(rd_addr_q) || is_mem(rd_addr_q) || (rd_addr_q == IP_LO_ADDR) ||
               (rd_addr_q == IP_HI_ADDR) || (rd_addr_q == STATUS_ADDR);

  // Memory read port serves the vector fetch first, then the bus
  wire [MEM_AW-1:0] mem_rd_addr = (state_q == HOLD_ST) ? VECTOR_LO_IDX :
                                  (state_q == FETCH_LO_ST) ? VECTOR_HI_IDX : araddr[7:2];

  data_memory #(
    .DEPTH(MEM_DEPTH),
    .AW(MEM_AW)
  ) u_data_memory (
    .aclk(aclk),
    .wr_en(mem_we),
    .wr_addr(wr_addr_q[7:2]),
    .wr_data(wr_byte_q),
    .rd_addr(mem_rd_addr),
    .rd_data(mem_rdata)
  );

  // Every peripheral register reloads its default on each reset cycle
  for (genvar i = 0; i < REG_COUNT; i++) begin : g_reg
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        if (i == WDT_IDX) begin
          regs_q[i] <= opt_sync ? WDT_CODE_SET : WDT_CODE_CLR;
        end else begin
          regs_q[i] <= REG_DEFAULT[i];
        end
      end else if (reg_we && (wr_idx == 7'(i))) begin
        regs_q[i] <= wr_byte_q;
      end
    end
    assign reg_image[8*i +: 8] = regs_q[i];
  end

  // Boot sequence: fetch low then high vector byte after release
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= HOLD_ST;
      pointer_valid_q <= 1'b0;
      retained_q <= standby_mode;
    end else begin
      case (state_q)
        HOLD_ST: state_q <= FETCH_LO_ST;
        FETCH_LO_ST: begin
          ip_lo_q <= mem_rdata;
          state_q <= FETCH_HI_ST;
        end
        FETCH_HI_ST: begin
          ip_hi_q <= mem_rdata;
          pointer_valid_q <= 1'b1;
          state_q <= RUN_ST;
        end
        default: state_q <= RUN_ST;
      endcase
    end
  end

  // Pointer bytes are left alone by reset; only the valid flag clears
  assign instruction_pointer = {ip_hi_q, ip_lo_q};
  assign pointer_valid = pointer_valid_q;

  // Write channel: address and data taken in any order, answered after both
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      wr_addr_q <= '0;
      wr_byte_q <= 8'h00;
      wr_lane_q <= 1'b0;
    end else begin
      aw_held_q <= aw_held_d;
      w_held_q <= w_held_d;
      bvalid_q <= bvalid_d;
      awready_q <= run && !aw_held_d && !bvalid_d;
      wready_q <= run && !w_held_d && !bvalid_d;
      if (aw_take) begin
        wr_addr_q <= awaddr;
      end
      if (w_take) begin
        wr_byte_q <= wdata[7:0];
        wr_lane_q <= wstrb[0];
      end
      if (do_write) begin
        bresp_q <= (wr_reg_hit || wr_mem_hit || wr_ro_hit) ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // Read channel: answer two cycles after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_pend_q <= 1'b0;
      rvalid_q <= 1'b0;
      arready_q <= 1'b0;
      rd_addr_q <= '0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= RESP_OKAY;
    end else begin
      rd_pend_q <= ar_take;
      rvalid_q <= rvalid_d;
      arready_q <= run && !ar_take && !rvalid_d;
      if (ar_take) begin
        rd_addr_q <= araddr;
      end
      if (rd_pend_q) begin
        rdata_q <= {24'h00_0000, rd_byte};
        rresp_q <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  assign awready = awready_q;
  assign wready = wready_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign arready = arready_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;

  // Checks on the defaults, the boot sequence, the memory guard and the bus answers
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Vector bytes seen written; until then memory and pointer hold no known value
  logic vec_lo_seen_q;
  logic vec_hi_seen_q;

  always_ff @(posedge aclk) begin
    if (mem_we && (wr_addr_q[7:2] == VECTOR_LO_IDX)) begin
      vec_lo_seen_q <= 1'b1;
    end
    if (mem_we && (wr_addr_q[7:2] == VECTOR_HI_IDX)) begin
      vec_hi_seen_q <= 1'b1;
    end
  end

  sequence release_seq;
    $rose(aresetn);
  endsequence

  sequence fetch_seq;
    state_q == FETCH_LO_ST ##1 state_q == FETCH_HI_ST;
  endsequence

  // Fetch from a vector that software has stored
  sequence seeded_fetch_seq;
    vec_lo_seen_q && vec_hi_seen_q ##0 fetch_seq;
  endsequence

  chk_vector_load: assert property (seeded_fetch_seq |=> pointer_valid_q &&
      ip_hi_q == $past(mem_rdata) && ip_lo_q == $past(mem_rdata, 2))
    else $error("pointer bytes not taken from vector");
  chk_boot_timing: assert property (release_seq |-> !pointer_valid_q ##3 pointer_valid_q)
    else $error("pointer not valid three cycles after release");
  chk_mem_guard: assert property (!run |-> !mem_we && !awready_q)
    else $error("memory written before boot finished");
  chk_port_defaults: assert property (release_seq |-> regs_q[PORT_DIR_IDX] == 8'hFF &&
      regs_q[PORT_LATCH_IDX] == 8'h00 && regs_q[PULLUP_IDX] == 8'h00)
    else $error("port defaults wrong after reset");
  chk_size_default: assert property (release_seq |-> regs_q[MEM_SIZE_IDX] == 8'hCF)
    else $error("memory size default wrong");
  chk_clock_defaults: assert property (release_seq |-> regs_q[PROC_CLK_IDX] == 8'h01 &&
      regs_q[INT_OSC_IDX] == 8'h80 && regs_q[MAIN_OSC_IDX] == 8'h80 && regs_q[SETTLE_SEL_IDX] == 8'h05 &&
      regs_q[CLK_MODE_IDX] == 8'h00 && regs_q[MAIN_CLK_MODE_IDX] == 8'h00 && regs_q[SETTLE_STATUS_IDX] == 8'h00)
    else $error("clock defaults wrong");
  chk_timer_defaults: assert property (release_seq |-> regs_q[WIDE_TIMER_IDX+5] == 8'h00 &&
      regs_q[BYTE_CTR_IDX+7] == 8'h00 && regs_q[INTERVAL_IDX+6] == 8'h00 && regs_q[WATCH_IDX+1] == 8'h00)
    else $error("timer defaults wrong");
  chk_serial_defaults: assert property (release_seq |-> regs_q[SERIAL_A_IDX+4] == 8'h1F &&
      regs_q[SERIAL_B_IDX+7] == 8'h16 && regs_q[SERIAL_B_IDX+2] == 8'h01 && regs_q[SERIAL_B_IDX+6] == 8'hFF)
    else $error("serial defaults wrong");
  chk_other_defaults: assert property (release_seq |-> regs_q[ADC_IDX] == 8'h00 &&
      regs_q[SERIAL_B_IDX+4] == 8'h00 && regs_q[SERIAL_B_IDX+8] == 8'h00 && regs_q[CSI_IDX+2] == 8'h00)
    else $error("converter or serial status defaults wrong");
  chk_watchdog_code: assert property (release_seq |-> regs_q[WDT_IDX] == ($past(opt_sync) ? 8'h9A : 8'h1A))
    else $error("watchdog code does not follow option");
  chk_write_hold: assert property (bvalid_q && !bready |=> bvalid_q && $stable(bresp_q))
    else $error("write response dropped before accepted");
  chk_read_hold: assert property (rvalid_q && !rready |=> rvalid_q && $stable(rdata_q) && $stable(rresp_q))
    else $error("read answer changed before accepted");
endmodule : reset_default_state_loader
`default_nettype wire

// [sim/reset_default_state_loader_test.sv]
// Testbench: drives the reset default loader over its register bus and checks defaults and boot.
// Assumes the design package and a lone 200 MHz clock; no partner model stands beside the block.
`timescale 1ns/100ps
`default_nettype none
module reset_default_state_loader_test;
  import reset_defaults_pkg::*;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, standby_mode, option_wdt_sel, pointer_valid;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd_word;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rd_resp, wr_resp;
  logic [8*REG_COUNT-1:0] reg_image;
  logic [15:0] instruction_pointer;
  int fails, compares, cycles;

  reset_default_state_loader u_reset_default_state_loader (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .standby_mode(standby_mode), .option_wdt_sel(option_wdt_sel),
    .reg_image(reg_image), .instruction_pointer(instruction_pointer), .pointer_valid(pointer_valid)
  );

  // Clock source, 5 ns period
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  // Hang guard: far above the few hundred cycles the sequence needs
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails++;
      wrap_up();
    end
  end

  // Expected value of each register index after reset
  function automatic logic [7:0] exp_def(input int i, input logic opt);
    case (i)
      6, 7, 8, 9, 10, 11, 12, 13, 60, 61, 65, 66, 71: exp_def = 8'hFF;
      18: exp_def = 8'hCF;
      20, 62, 67: exp_def = 8'h01;
      21, 22: exp_def = 8'h80;
      25: exp_def = 8'h05;
      64: exp_def = 8'h1F;
      72: exp_def = 8'h16;
      53: exp_def = opt ? 8'h9A : 8'h1A;
      default: exp_def = 8'h00;
    endcase
  endfunction : exp_def

  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask : check

  // Bus write of one byte; entered just after a rising edge
  task automatic axi_write(input logic [11:0] a, input logic [7:0] d, input logic [3:0] s);
    awaddr <= a;
    wdata <= {24'h00_0000, d};
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    wr_resp = bresp;
    bready <= 1'b0;
    @(posedge aclk);
  endtask : axi_write

  // Bus read of one word; answer taken at the handshake edge
  task automatic axi_read(input logic [11:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rd_word = rdata;
    rd_resp = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask : axi_read

  // Reset pulse, default image check just after release, then boot of the pointer
  task automatic do_boot(input logic sb, input logic opt, input logic ip_chk, input logic [15:0] ip_exp);
    aresetn <= 1'b0;
    standby_mode <= sb;
    option_wdt_sel <= opt;
    // Five reset edges; the option level settles by the fourth, so the fifth loads it
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    #1;
    check({31'h0000_0000, pointer_valid}, 32'h0000_0000);
    for (int i = 0; i < REG_COUNT; i++) check(reg_image[8*i +: 8], exp_def(i, opt));
    repeat (3) @(posedge aclk);
    #1;
    check({31'h0000_0000, pointer_valid}, 32'h0000_0001);
    if (ip_chk) check(instruction_pointer, ip_exp);
    @(posedge aclk);
  endtask : do_boot

  // Verdict and end of run
  task automatic wrap_up();
    if (fails == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : wrap_up

  // Main sequence
  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr, wdata, wstrb} = '0;
    fails = 0;
    compares = 0;
    cycles = 0;
    do_boot(1'b0, 1'b0, 1'b0, 16'h0000);
    // Every default read back over the bus, upper bits zero
    for (int i = 0; i < REG_COUNT; i++) begin
      axi_read(12'(4 * i));
      check(rd_word, {24'h00_0000, exp_def(i, 1'b0)});
      check(rd_resp, RESP_OKAY);
    end
    // Software rewrites the memory size register
    axi_write(12'h048, 8'hC8, 4'h1);
    check(wr_resp, RESP_OKAY);
    axi_read(12'h048);
    check(rd_word, 32'h0000_00C8);
    // Disabled byte lane stores nothing; enabled lane stores
    axi_write(12'h000, 8'h77, 4'h0);
    check(reg_image[7:0], 8'h00);
    axi_write(12'h000, 8'h5A, 4'h1);
    check(reg_image[7:0], 8'h5A);
    // Unmapped place answers with an error and zero data
    axi_read(12'h144);
    check(rd_resp, RESP_SLVERR);
    check(rd_word, 32'h0000_0000);
    axi_write(12'h144, 8'h11, 4'h1);
    check(wr_resp, RESP_SLVERR);
    // Vector bytes in data memory, then a reset taken in standby
    axi_write(MEM_BASE, 8'h34, 4'h1);
    axi_write(MEM_BASE + 12'h004, 8'h12, 4'h1);
    axi_write(MEM_BASE + 12'h008, 8'hA5, 4'h1);
    do_boot(1'b1, 1'b1, 1'b1, 16'h1234);
    axi_read(MEM_BASE + 12'h008);
    check(rd_word, 32'h0000_00A5);
    axi_read(STATUS_ADDR);
    check(rd_word, 32'h0000_0007);
    axi_write(IP_LO_ADDR, 8'h99, 4'h1);
    check(wr_resp, RESP_OKAY);
    axi_read(IP_LO_ADDR);
    check(rd_word, 32'h0000_0034);
    axi_read(12'h048);
    check(rd_word, 32'h0000_00CF);
    // Plain reset again loads the pointer from the vector
    do_boot(1'b0, 1'b0, 1'b1, 16'h1234);
    axi_read(STATUS_ADDR);
    check(rd_word, 32'h0000_0001);
    wrap_up();
  end
endmodule : reset_default_state_loader_test
`default_nettype wire
